// ===== gpb_regs.svh
// Register indices, reset values and bit masks
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

// Register indices; byte address is four times the index
`define GPB_IDX_A_DIR 10'h2c0
`define GPB_IDX_A_PIN 10'h2c2
`define GPB_IDX_A_LAT 10'h2c4
`define GPB_IDX_B_DIR 10'h2c6
`define GPB_IDX_B_PIN 10'h2c8
`define GPB_IDX_B_LAT 10'h2cb
`define GPB_IDX_C_DIR 10'h2cc
`define GPB_IDX_C_PIN 10'h2ce
`define GPB_IDX_C_LAT 10'h2d0
`define GPB_IDX_ANSEL 10'h2f0

// Direction reset values
`define GPB_A_DIR_RST 16'hf6c0
`define GPB_B_DIR_RST 16'hffff
`define GPB_C_DIR_RST 16'he01e
// Latch and pin-read reset value
`define GPB_ZERO_RST 16'h0000
// Analog select reset: all pins digital
`define GPB_ANSEL_RST 16'h0000

// Implemented bit masks
`define GPB_A_IMPL 16'hf6c0
`define GPB_B_IMPL 16'hffff
`define GPB_C_IMPL 16'he01e

`endif

// ===== gpb_pkg.sv
// Types shared by the port bank and the top level
`default_nettype none
package gpb_pkg;

  // Write command delivered to one bank
  typedef struct packed {
    logic wr_dir;          // Direction register write
    logic wr_lat;          // Latch write (latch or pin-read address)
    logic [15:0] data;     // Write data
    logic [15:0] bmask;    // Byte-lane mask from pstrb
  } gpb_wr_t;

  // State a bank reports back
  typedef struct packed {
    logic [15:0] dir;      // Direction, 1 = input
    logic [15:0] lat;      // Output latch
    logic [15:0] pin;      // Sampled, masked pin levels
  } gpb_stat_t;

  // Register selected by an address, one-hot
  typedef enum logic [10:0] {
    GPB_SEL_NONE  = 11'b000_0000_0001,
    GPB_SEL_A_DIR = 11'b000_0000_0010,
    GPB_SEL_A_PIN = 11'b000_0000_0100,
    GPB_SEL_A_LAT = 11'b000_0000_1000,
    GPB_SEL_B_DIR = 11'b000_0001_0000,
    GPB_SEL_B_PIN = 11'b000_0010_0000,
    GPB_SEL_B_LAT = 11'b000_0100_0000,
    GPB_SEL_C_DIR = 11'b000_1000_0000,
    GPB_SEL_C_PIN = 11'b001_0000_0000,
    GPB_SEL_C_LAT = 11'b010_0000_0000,
    GPB_SEL_ANSEL = 11'b100_0000_0000
  } gpb_sel_t;

endpackage
`default_nettype wire

// ===== gpb_bank.sv
// One parallel port bank: direction, latch, pin sampling and pad drive
`default_nettype none
module gpb_bank #(
  parameter logic [15:0] IMPL = 16'hffff,
  parameter logic [15:0] DIR_RST = 16'hffff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire gpb_pkg::gpb_wr_t wr,
  input wire logic [15:0] analog_sel,
  input wire logic [15:0] periph_own,
  input wire logic [15:0] pin_in,
  output var gpb_pkg::gpb_stat_t stat,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_n
);
  import gpb_pkg::*;

  logic [15:0] dir_reg, dir_next;     // Direction, 1 = input
  logic [15:0] lat_reg, lat_next;     // Output latch
  logic [15:0] pin_reg, pin_next;     // Sampled pin levels
  logic [15:0] oe_n_reg, oe_n_next;   // Pad enable, low drives
  logic [15:0] wmask;                 // Bits a write may touch

  // Next-state for all bank state
  always_comb begin
    // Only implemented bits in enabled byte lanes change
    wmask = wr.bmask & IMPL;
    dir_next = dir_reg;
    lat_next = lat_reg;
    if (wr.wr_dir) begin
      dir_next = (dir_reg & ~wmask) | (wr.data & wmask);
    end
    // Pin-read writes land in the latch too
    if (wr.wr_lat) begin
      lat_next = (lat_reg & ~wmask) | (wr.data & wmask);
    end
    // Analog pins and missing bits read low
    pin_next = pin_in & IMPL & ~analog_sel;
    // Driver off for inputs and for peripheral-owned pins; pin still read
    oe_n_next = (dir_next | periph_own | ~IMPL);
  end

  // Registers; enable follows the direction write on the same edge
  // so the pad and the next sample line up one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= DIR_RST;
      lat_reg <= 16'h0000;
      pin_reg <= 16'h0000;
      oe_n_reg <= 16'hffff;
    end else begin
      dir_reg <= dir_next;
      lat_reg <= lat_next;
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Report state; missing bits are never stored, so they read zero
  assign stat.dir = dir_reg;
  assign stat.lat = lat_reg;
  assign stat.pin = pin_reg;
  assign pin_out = lat_reg;
  assign pin_oe_n = oe_n_reg;

endmodule
`default_nettype wire

// ===== gpb_gpio.sv
// Top level: APB register slave over three port banks and analog routing
`include "gpb_regs.svh"
`default_nettype none
module gpb_gpio #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pin_a_in,
  output logic [15:0] pin_a_out,
  output logic [15:0] pin_a_oe_n,
  input wire logic [15:0] pin_b_in,
  output logic [15:0] pin_b_out,
  output logic [15:0] pin_b_oe_n,
  input wire logic [15:0] pin_c_in,
  output logic [15:0] pin_c_out,
  output logic [15:0] pin_c_oe_n,
  input wire logic [15:0] periph_own_a,
  input wire logic [15:0] periph_own_b,
  input wire logic [15:0] periph_own_c,
  output logic [15:0] adc_route,
  output logic [15:0] adc_level
);
  import gpb_pkg::*;

  // Map a word index to the register it selects
  function automatic gpb_sel_t gpb_decode(input logic [9:0] idx);
    gpb_sel_t s;
    s = GPB_SEL_NONE;
    unique case (idx)
      `GPB_IDX_A_DIR: s = GPB_SEL_A_DIR;
      `GPB_IDX_A_PIN: s = GPB_SEL_A_PIN;
      `GPB_IDX_A_LAT: s = GPB_SEL_A_LAT;
      `GPB_IDX_B_DIR: s = GPB_SEL_B_DIR;
      `GPB_IDX_B_PIN: s = GPB_SEL_B_PIN;
      `GPB_IDX_B_LAT: s = GPB_SEL_B_LAT;
      `GPB_IDX_C_DIR: s = GPB_SEL_C_DIR;
      `GPB_IDX_C_PIN: s = GPB_SEL_C_PIN;
      `GPB_IDX_C_LAT: s = GPB_SEL_C_LAT;
      `GPB_IDX_ANSEL: s = GPB_SEL_ANSEL;
      default: s = GPB_SEL_NONE;
    endcase
    return s;
  endfunction

  // Bus answer registers
  logic [31:0] prdata_reg, prdata_next;  // Read data for access phase
  logic pready_reg, pready_next;         // Access-phase ready
  logic pslverr_reg, pslverr_next;       // Unmapped-address error
  // Analog select, 1 = bank B pin is an analog channel
  logic [15:0] ansel_reg, ansel_next;
  // Converter-facing outputs
  logic [15:0] route_reg, route_next;    // Pins routed to converter
  logic [15:0] level_reg, level_next;    // Level seen on driven pins

  // Decoded bus request
  gpb_sel_t sel;                         // Register under address
  logic setup;                           // First cycle of a transfer
  logic wr_do;                           // Write commits this edge
  logic [15:0] bmask;                    // Lanes from pstrb
  logic [15:0] wdata;                    // Low half of write data

  // Per-bank carriers
  gpb_wr_t bank_wr [3];                  // Commands to banks
  gpb_stat_t bank_stat [3];              // State from banks
  logic [15:0] bank_pin_in [3];          // Pad levels into banks
  logic [15:0] bank_own [3];             // Peripheral ownership
  logic [15:0] bank_ansel [3];           // Analog masks per bank
  logic [15:0] bank_out [3];             // Latch drive to pads
  logic [15:0] bank_oe_n [3];            // Pad enables

  // Request decode; the index is paddr above the byte offset
  always_comb begin
    sel = gpb_decode(paddr[11:2]);
    setup = psel & ~penable;
    // Write commits only at the edge where ready is sampled high
    wr_do = psel & penable & pwrite & pready_reg;
    bmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wdata = pwdata[15:0];
  end

  // Pad wiring into the bank array
  always_comb begin
    bank_pin_in[0] = pin_a_in;
    bank_pin_in[1] = pin_b_in;
    bank_pin_in[2] = pin_c_in;
    bank_own[0] = periph_own_a;
    bank_own[1] = periph_own_b;
    bank_own[2] = periph_own_c;
    // Only bank B carries analog channel pins
    bank_ansel[0] = 16'h0000;
    bank_ansel[1] = ansel_reg;
    bank_ansel[2] = 16'h0000;
  end

  // Write commands to the banks; a pin-read write updates the latch
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      bank_wr[i].wr_dir = 1'b0;
      bank_wr[i].wr_lat = 1'b0;
      bank_wr[i].data = wdata;
      bank_wr[i].bmask = bmask;
    end
    if (wr_do) begin
      bank_wr[0].wr_dir = (sel == GPB_SEL_A_DIR);
      bank_wr[0].wr_lat = (sel == GPB_SEL_A_LAT) ||
                          (sel == GPB_SEL_A_PIN);
      bank_wr[1].wr_dir = (sel == GPB_SEL_B_DIR);
      bank_wr[1].wr_lat = (sel == GPB_SEL_B_LAT) ||
                          (sel == GPB_SEL_B_PIN);
      bank_wr[2].wr_dir = (sel == GPB_SEL_C_DIR);
      bank_wr[2].wr_lat = (sel == GPB_SEL_C_LAT) ||
                          (sel == GPB_SEL_C_PIN);
    end
  end

  // Three banks with their own implemented masks and reset directions
  gpb_bank #(
    .IMPL(`GPB_A_IMPL),
    .DIR_RST(`GPB_A_DIR_RST)
  ) u_bank_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr(bank_wr[0]),
    .analog_sel(bank_ansel[0]),
    .periph_own(bank_own[0]),
    .pin_in(bank_pin_in[0]),
    .stat(bank_stat[0]),
    .pin_out(bank_out[0]),
    .pin_oe_n(bank_oe_n[0])
  );

  gpb_bank #(
    .IMPL(`GPB_B_IMPL),
    .DIR_RST(`GPB_B_DIR_RST)
  ) u_bank_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr(bank_wr[1]),
    .analog_sel(bank_ansel[1]),
    .periph_own(bank_own[1]),
    .pin_in(bank_pin_in[1]),
    .stat(bank_stat[1]),
    .pin_out(bank_out[1]),
    .pin_oe_n(bank_oe_n[1])
  );

  gpb_bank #(
    .IMPL(`GPB_C_IMPL),
    .DIR_RST(`GPB_C_DIR_RST)
  ) u_bank_c (
    .pclk(pclk),
    .presetn(presetn),
    .wr(bank_wr[2]),
    .analog_sel(bank_ansel[2]),
    .periph_own(bank_own[2]),
    .pin_in(bank_pin_in[2]),
    .stat(bank_stat[2]),
    .pin_out(bank_out[2]),
    .pin_oe_n(bank_oe_n[2])
  );

  // Pads come straight from bank flops
  assign pin_a_out = bank_out[0];
  assign pin_a_oe_n = bank_oe_n[0];
  assign pin_b_out = bank_out[1];
  assign pin_b_oe_n = bank_oe_n[1];
  assign pin_c_out = bank_out[2];
  assign pin_c_oe_n = bank_oe_n[2];

  // Bus answer: data is gathered in setup, so the slave answers
  // every access with zero wait states
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = setup;
    pslverr_next = setup & (sel == GPB_SEL_NONE);
    if (setup) begin
      prdata_next = 32'h0000_0000;
      // Upper half always zero; register data sits low
      unique case (sel)
        GPB_SEL_A_DIR: prdata_next[15:0] = bank_stat[0].dir;
        GPB_SEL_A_PIN: prdata_next[15:0] = bank_stat[0].pin;
        GPB_SEL_A_LAT: prdata_next[15:0] = bank_stat[0].lat;
        GPB_SEL_B_DIR: prdata_next[15:0] = bank_stat[1].dir;
        GPB_SEL_B_PIN: prdata_next[15:0] = bank_stat[1].pin;
        GPB_SEL_B_LAT: prdata_next[15:0] = bank_stat[1].lat;
        GPB_SEL_C_DIR: prdata_next[15:0] = bank_stat[2].dir;
        GPB_SEL_C_PIN: prdata_next[15:0] = bank_stat[2].pin;
        GPB_SEL_C_LAT: prdata_next[15:0] = bank_stat[2].lat;
        GPB_SEL_ANSEL: prdata_next[15:0] = ansel_reg;
        GPB_SEL_NONE: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Analog select and converter routing
  always_comb begin
    ansel_next = ansel_reg;
    if (wr_do && (sel == GPB_SEL_ANSEL)) begin
      ansel_next = (ansel_reg & ~bmask) | (wdata & bmask);
    end
    // Digital-selected pins never reach the converter
    route_next = ansel_next;
    // An analog pin set as output converts the level being driven;
    // software is expected to keep analog pins as inputs
    level_next = ansel_next & ~bank_stat[1].dir &
                 bank_stat[1].lat;
  end

  // Bus and analog registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ansel_reg <= `GPB_ANSEL_RST;
      route_reg <= `GPB_ANSEL_RST;
      level_reg <= 16'h0000;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ansel_reg <= ansel_next;
      route_reg <= route_next;
      level_reg <= level_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign adc_route = route_reg;
  assign adc_level = level_reg;

endmodule
`default_nettype wire

// ===== gpb_checker.sv
// Port-level assertions for the three-bank port block
`include "gpb_regs.svh"
`default_nettype none
module gpb_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [15:0] pin_a_out,
  input wire logic [15:0] pin_a_oe_n,
  input wire logic [15:0] pin_b_out,
  input wire logic [15:0] pin_b_oe_n,
  input wire logic [15:0] pin_c_out,
  input wire logic [15:0] pin_c_oe_n,
  input wire logic [15:0] periph_own_a,
  input wire logic [15:0] periph_own_b,
  input wire logic [15:0] adc_route,
  input wire logic [15:0] adc_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Full-word write committing at this edge
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite && pstrb == 4'hf;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("pready missing after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");
  property p_lat_a;
    wr_done && paddr == {`GPB_IDX_A_LAT, 2'b00}
      |=> pin_a_out == ($past(pwdata[15:0]) & `GPB_A_IMPL);
  endproperty
  a_lat_a: assert property (p_lat_a)
    else $error("bank a pads do not follow latch write");
  property p_dir_a;
    wr_done && paddr == {`GPB_IDX_A_DIR, 2'b00} && periph_own_a == 0
      |=> pin_a_oe_n == ($past(pwdata[15:0]) | ~`GPB_A_IMPL);
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("bank a driver enables do not follow direction");
  property p_lat_c;
    wr_done && paddr == {`GPB_IDX_C_LAT, 2'b00}
      |=> pin_c_out == ($past(pwdata[15:0]) & `GPB_C_IMPL);
  endproperty
  a_lat_c: assert property (p_lat_c)
    else $error("bank c pads do not follow latch write");
  property p_impl_a;
    (pin_a_oe_n | `GPB_A_IMPL) == 16'hffff && (pin_a_out & ~`GPB_A_IMPL) == 0;
  endproperty
  a_impl_a: assert property (p_impl_a)
    else $error("bank a unimplemented pin active");
  property p_impl_c;
    (pin_c_oe_n | `GPB_C_IMPL) == 16'hffff && (pin_c_out & ~`GPB_C_IMPL) == 0;
  endproperty
  a_impl_c: assert property (p_impl_c)
    else $error("bank c unimplemented pin active");
  property p_own_b;
    periph_own_b != 0
      |=> (pin_b_oe_n & $past(periph_own_b)) == $past(periph_own_b);
  endproperty
  a_own_b: assert property (p_own_b)
    else $error("port drives a pad the peripheral owns");
  property p_adc;
    periph_own_b == 0 && $stable(periph_own_b) && $stable(adc_route)
      && $stable(pin_b_out) && $stable(pin_b_oe_n)
      |-> adc_level == (adc_route & ~pin_b_oe_n & pin_b_out);
  endproperty
  a_adc: assert property (p_adc)
    else $error("converter level differs from driven level");
endmodule
bind gpb_gpio gpb_checker #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pin_a_out,
  .pin_a_oe_n, .pin_b_out, .pin_b_oe_n, .pin_c_out, .pin_c_oe_n,
  .periph_own_a, .periph_own_b, .adc_route, .adc_level);
`default_nettype wire

// ===== gpb_pad_model.sv
// Pad model for one bank of external pins
`default_nettype none
module gpb_pad_model (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_en,
  output logic [15:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port wins where enabled, else the outside drive; a floating pad
  // shows the inverse of the latch so a stale level never passes
  assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & ~pin_out);
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the three-bank port block
`include "gpb_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Register index, reset value, value read after writing all ones
  typedef struct {
    logic [9:0] idx;
    logic [15:0] rst;
    logic [15:0] back;
  } gpb_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, c_in, c_out;
  logic [15:0] c_oe_n, own_a, own_b, own_c, route, level, ext_b, en_b;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  gpb_row_t rows [9];
  gpb_gpio uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe_n(a_oe_n),
    .pin_b_in(b_in), .pin_b_out(b_out), .pin_b_oe_n(b_oe_n),
    .pin_c_in(c_in), .pin_c_out(c_out), .pin_c_oe_n(c_oe_n),
    .periph_own_a(own_a), .periph_own_b(own_b),
    .periph_own_c(own_c), .adc_route(route), .adc_level(level));
  // Banks a and c see a quiet low world, bank b a bench-set one
  gpb_pad_model pad_a (.pin_out(a_out), .pin_oe_n(a_oe_n),
    .ext_val(16'h0000), .ext_en(16'hffff), .pin_lvl(a_in));
  gpb_pad_model pad_b (.pin_out(b_out), .pin_oe_n(b_oe_n),
    .ext_val(ext_b), .ext_en(en_b), .pin_lvl(b_in));
  gpb_pad_model pad_c (.pin_out(c_out), .pin_oe_n(c_oe_n),
    .ext_val(16'h0000), .ext_en(16'hffff), .pin_lvl(c_in));
  // Clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; always one idle edge before setup
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rows = '{'{`GPB_IDX_A_DIR, `GPB_A_DIR_RST, `GPB_A_IMPL},
      '{`GPB_IDX_A_LAT, 16'h0000, `GPB_A_IMPL}, '{`GPB_IDX_A_PIN, 0, 0},
      '{`GPB_IDX_B_DIR, `GPB_B_DIR_RST, `GPB_B_IMPL},
      '{`GPB_IDX_B_LAT, 16'h0000, `GPB_B_IMPL}, '{`GPB_IDX_B_PIN, 0, 0},
      '{`GPB_IDX_C_DIR, `GPB_C_DIR_RST, `GPB_C_IMPL},
      '{`GPB_IDX_C_LAT, 16'h0000, `GPB_C_IMPL}, '{`GPB_IDX_C_PIN, 0, 0}};
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    own_a = 16'h0000;
    own_b = 16'h0000;
    own_c = 16'h0000;
    ext_b = 16'h0000;
    en_b = 16'hffff;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe_n b", b_oe_n, 16'hffff);
    chk("route", route, 16'h0000);
    // Reset value, then all ones written and read back, per register
    foreach (rows[i]) begin
      apb(1'b0, rows[i].idx, 16'h0000);
      chk("reset value", rd, rows[i].rst);
      apb(1'b1, rows[i].idx, 16'hffff);
      apb(1'b0, rows[i].idx, 16'h0000);
      chk("read back", rd, rows[i].back);
    end
    chk("a pads", a_out, `GPB_A_IMPL);
    // Low byte driven, high byte from outside
    ext_b <= 16'ha500;
    apb(1'b1, `GPB_IDX_B_DIR, 16'hff00);
    apb(1'b1, `GPB_IDX_B_LAT, 16'h0055);
    apb(1'b0, `GPB_IDX_B_PIN, 16'h0000);
    chk("pins b", rd, 32'h0000_a555);
    chk("drive b", b_oe_n, 16'hff00);
    // Peripheral takes pin 0; outside lets it float
    own_b <= 16'h0001;
    en_b <= 16'hfffe;
    repeat (3) @(posedge pclk);
    apb(1'b0, `GPB_IDX_B_PIN, 16'h0000);
    chk("owned pin", rd, 32'h0000_a554);
    chk("owned oe", b_oe_n, 16'hff01);
    own_b <= 16'h0000;
    en_b <= 16'hffff;
    // Analog on nibbles 0 and 2, with outputs among them
    apb(1'b1, `GPB_IDX_ANSEL, 16'h0f0f);
    apb(1'b0, `GPB_IDX_B_PIN, 16'h0000);
    chk("analog read", rd, 32'h0000_a050);
    chk("route", route, 16'h0f0f);
    chk("level", level, 16'h0005);
    // Unmapped place refuses
    apb(1'b1, 10'h3ff, 16'hffff);
    chk("refused", err, 1'b1);
    apb(1'b0, 10'h3ff, 16'h0000);
    chk("unmapped", rd, 32'h0000_0000);
    // Low lane only; high byte of the latch must stay
    pstrb <= 4'h1;
    apb(1'b1, `GPB_IDX_B_LAT, 16'hffff);
    pstrb <= 4'hf;
    apb(1'b0, `GPB_IDX_B_LAT, 16'h0000);
    chk("lane write", rd, 32'h0000_00ff);
    chk("level lanes", level, 16'h000f);
    // Analog pins back to inputs; nothing driven is converted
    apb(1'b1, `GPB_IDX_B_DIR, 16'h0f0f);
    apb(1'b0, `GPB_IDX_B_DIR, 16'h0000);
    chk("dir b", rd, 32'h0000_0f0f);
    chk("level inputs", level, 16'h0000);
    // Banks a and c drive, then a peripheral takes some pins
    apb(1'b1, `GPB_IDX_A_DIR, 16'h0000);
    apb(1'b1, `GPB_IDX_C_DIR, 16'h0000);
    apb(1'b0, `GPB_IDX_C_PIN, 16'h0000);
    chk("pins c", rd, 32'h0000_e01e);
    chk("drive c", c_oe_n, 16'h1fe1);
    own_a <= 16'h0040;
    own_c <= 16'he01e;
    repeat (2) @(posedge pclk);
    chk("owned a", a_oe_n, 16'h097f);
    chk("owned c", c_oe_n, 16'hffff);
    apb(1'b0, `GPB_IDX_A_PIN, 16'h0000);
    chk("owned a read", rd, 32'h0000_f680);
    own_a <= 16'h0000;
    own_c <= 16'h0000;
    // Second reset in mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GPB_IDX_B_DIR, 16'h0000);
    chk("dir after reset", rd, 32'h0000_ffff);
    chk("level after reset", level, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
